// ---- rtl/ltm_consts.vh ----
`ifndef LTM_CONSTS_VH
`define LTM_CONSTS_VH

// Register byte offsets
`define LTM_OFF_MODE       8'h00
`define LTM_OFF_CONFIG     8'h04
`define LTM_OFF_FAULT      8'h08
`define LTM_OFF_WAKE       8'h0C
`define LTM_OFF_STATUS     8'h10

// Channel mode codes
`define LTM_MODE_OFF       2'h0
`define LTM_MODE_WAKE      2'h1
`define LTM_MODE_RXONLY    2'h2
`define LTM_MODE_NORMAL    2'h3
`define LTM_MODE_RESET     8'h00

// Chip power mode codes
`define LTM_CM_NORMAL      3'h0
`define LTM_CM_STOP        3'h1
`define LTM_CM_SLEEP       3'h2
`define LTM_CM_RESTART     3'h3
`define LTM_CM_FAILSAFE    3'h4

// Config bit positions and reset value
`define LTM_CFG_TXTO_EN    0
`define LTM_CFG_LOW_SLOPE  1
`define LTM_CFG_WD_WAKE    2
`define LTM_CFG_RESET      3'h1

// Status field positions
`define LTM_ST_TXTO_LSB    4
`define LTM_ST_UV          8
`define LTM_ST_CM_LSB      9

// Timing in 8 ns clock cycles, sized to their counters
`define LTM_WAKE_CYC       13'hEA6
`define LTM_WK_W           13
`define LTM_EN_CYC         11'h4E2
`define LTM_EN_W           11
`define LTM_DOM_TO_CYC     22'h2625A0
`define LTM_TO_W           22

`endif

// ---- rtl/ltm_lin_mode_ctrl.v ----
`timescale 1ns/1ps
`include "ltm_consts.vh"

module ltm_lin_mode_ctrl #(
	parameter [`LTM_TO_W-1:0] DOM_TO_CYC = `LTM_DOM_TO_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	input  wire [2:0]  chip_mode,
	input  wire        chip_mode_load,
	input  wire [3:0]  tx_serial_in,
	input  wire [3:0]  bus_level_in,
	input  wire        supply_uv_in,
	output wire [3:0]  rx_serial_out,
	output wire [3:0]  bus_drive_dom,
	output reg         low_slope_out,
	output reg         wake_irq_pulse,
	output reg         watchdog_enable_req,
	output reg         restart_req
);

	// Mode acceptance per chip power mode
	function allowed;
		input [1:0] m;
		input [2:0] c;
		begin
			case (m)
				`LTM_MODE_OFF:    allowed = 1'b1;
				`LTM_MODE_NORMAL: allowed = (c == `LTM_CM_NORMAL);
				`LTM_MODE_RXONLY: allowed = (c == `LTM_CM_NORMAL) ||
					(c == `LTM_CM_STOP);
				default:          allowed = 1'b1;
			endcase
		end
	endfunction

	reg  [8:0]  sync1_q;
	reg  [8:0]  sync2_q;
	reg  [8:0]  sync3_q;
	reg  [8:0]  filt_q;
	reg  [2:0]  cfg_q;
	wire [3:0]  tx_f;
	wire [3:0]  bus_f;
	wire        uv_f;
	wire [7:0]  mode_all;
	wire [3:0]  fault_all;
	wire [3:0]  wstat_all;
	wire [3:0]  woken_all;
	wire [3:0]  txto_all;
	wire [3:0]  wk_ev;
	wire        wr_en;
	wire        rd_setup;
	wire        wr_mode;
	wire        wr_cfg;
	wire        wr_fault;
	wire        wr_wake;
	wire        rearm_all;
	wire        in_normal;
	wire        any_wake;
	reg  [31:0] rd_d;
	reg         err_d;

	// Three-stage input sync, change taken when stages two and three agree
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Idle pin levels, so no false supply fault after reset
			sync1_q <= 9'h0FF;
			sync2_q <= 9'h0FF;
			sync3_q <= 9'h0FF;
			filt_q  <= 9'h0FF;
		end else begin
			sync1_q <= {supply_uv_in, bus_level_in, tx_serial_in};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q  <= (~(sync2_q ^ sync3_q) & sync3_q) |
				((sync2_q ^ sync3_q) & filt_q);
		end
	end

	assign tx_f  = filt_q[3:0];
	assign bus_f = filt_q[7:4];
	assign uv_f  = filt_q[8];

	// Zero-wait APB slave
	assign pready    = 1'b1;
	assign wr_en     = psel & penable & pwrite;
	assign rd_setup  = psel & ~penable;
	assign wr_mode   = wr_en && (paddr == `LTM_OFF_MODE);
	assign wr_cfg    = wr_en && (paddr == `LTM_OFF_CONFIG);
	assign wr_fault  = wr_en && (paddr == `LTM_OFF_FAULT);
	assign wr_wake   = wr_en && (paddr == `LTM_OFF_WAKE);
	assign in_normal = (chip_mode == `LTM_CM_NORMAL);
	// rearm on stop, sleep, fail-safe entry
	assign rearm_all = chip_mode_load &&
		((chip_mode == `LTM_CM_STOP) || (chip_mode == `LTM_CM_SLEEP) ||
		(chip_mode == `LTM_CM_FAILSAFE));
	assign any_wake  = |wk_ev;

	// Read mux and unmapped answer
	always @* begin
		rd_d  = 32'h0;
		err_d = 1'b0;
		case (paddr)
			`LTM_OFF_MODE:   rd_d[7:0] = mode_all;
			`LTM_OFF_CONFIG: rd_d[2:0] = cfg_q;
			`LTM_OFF_FAULT:  rd_d[3:0] = fault_all;
			`LTM_OFF_WAKE:   rd_d[3:0] = wstat_all;
			`LTM_OFF_STATUS: begin
				rd_d[3:0] = woken_all;
				rd_d[`LTM_ST_TXTO_LSB+3:`LTM_ST_TXTO_LSB] = txto_all;
				rd_d[`LTM_ST_UV] = uv_f;
				rd_d[`LTM_ST_CM_LSB+2:`LTM_ST_CM_LSB] = chip_mode;
			end
			default: err_d = 1'b1;
		endcase
	end

	// Read data and error captured in setup phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			prdata  <= pwrite ? 32'h0 : rd_d;
			pslverr <= err_d;
		end
	end

	// Config; low slope taken at write end in normal mode only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q         <= `LTM_CFG_RESET;
			low_slope_out <= 1'b0;
		end else begin
			if (wr_cfg) begin
				cfg_q[`LTM_CFG_TXTO_EN] <= pwdata[`LTM_CFG_TXTO_EN];
				cfg_q[`LTM_CFG_WD_WAKE] <= pwdata[`LTM_CFG_WD_WAKE];
			end
			// slope change accepted in normal mode
			if (wr_cfg && in_normal) begin
				cfg_q[`LTM_CFG_LOW_SLOPE] <= pwdata[`LTM_CFG_LOW_SLOPE];
			end
			low_slope_out <= cfg_q[`LTM_CFG_LOW_SLOPE];
		end
	end

	// Chip-level wake reactions
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_irq_pulse      <= 1'b0;
			watchdog_enable_req <= 1'b0;
			restart_req         <= 1'b0;
		end else begin
			// interrupt in stop or normal; no mode change
			wake_irq_pulse <= any_wake &&
				(in_normal || (chip_mode == `LTM_CM_STOP));
			watchdog_enable_req <= any_wake && cfg_q[`LTM_CFG_WD_WAKE] &&
				(chip_mode == `LTM_CM_STOP);
			restart_req <= any_wake && ((chip_mode == `LTM_CM_SLEEP) ||
				(chip_mode == `LTM_CM_FAILSAFE));
		end
	end

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_ch
			reg  [1:0]             mode_q;
			reg  [1:0]             mode_d;
			reg                    woken_q;
			reg  [`LTM_WK_W-1:0]   wk_cnt_q;
			reg                    wk_long_q;
			reg                    bus_prev_q;
			reg  [`LTM_TO_W-1:0]   txto_cnt_q;
			reg  [`LTM_TO_W-1:0]   bus_cnt_q;
			reg                    tx_to_q;
			reg  [`LTM_EN_W-1:0]   en_cnt_q;
			reg                    en_block_q;
			reg                    fault_q;
			reg                    wstat_q;
			reg                    rx_q;
			reg                    drv_q;
			wire                   tx_dom;
			wire                   bus_dom;
			wire                   armed;
			wire                   wake_now;
			wire                   fault_set;
			wire                   clamp_hit;
			wire                   txto_hit;
			wire                   drive_ok;

			assign tx_dom  = ~tx_f[i];
			assign bus_dom = ~bus_f[i];
			// only an armed wake-mode channel looks for wake
			assign armed   = (mode_q == `LTM_MODE_WAKE) && !woken_q;
			// wake on recessive edge after long dominant
			assign wake_now = armed && wk_long_q && bus_prev_q && !bus_dom;
			assign clamp_hit = ((mode_q == `LTM_MODE_NORMAL) ||
				(mode_q == `LTM_MODE_RXONLY)) && bus_dom &&
				(bus_cnt_q == DOM_TO_CYC);
			assign txto_hit = cfg_q[`LTM_CFG_TXTO_EN] && drive_ok &&
				tx_dom && (txto_cnt_q == DOM_TO_CYC);
			assign fault_set = clamp_hit || txto_hit;
			assign drive_ok = (mode_q == `LTM_MODE_NORMAL) && !uv_f &&
				!en_block_q && !tx_to_q;

			// Next channel mode
			always @* begin
				mode_d = mode_q;
				if (wr_mode && allowed(pwdata[2*i+1:2*i], chip_mode)) begin
					mode_d = pwdata[2*i+1:2*i];
				end
				if (chip_mode_load) begin
					if (chip_mode == `LTM_CM_FAILSAFE) begin
						mode_d = `LTM_MODE_WAKE;
					end else if (!allowed(mode_q, chip_mode)) begin
						mode_d = (chip_mode == `LTM_CM_STOP) ?
							`LTM_MODE_RXONLY : `LTM_MODE_WAKE;
					end
				end
			end

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mode_q     <= `LTM_MODE_OFF;
					woken_q    <= 1'b0;
					wk_cnt_q   <= {`LTM_WK_W{1'b0}};
					wk_long_q  <= 1'b0;
					bus_prev_q <= 1'b0;
					txto_cnt_q <= {`LTM_TO_W{1'b0}};
					bus_cnt_q  <= {`LTM_TO_W{1'b0}};
					tx_to_q    <= 1'b0;
					en_cnt_q   <= {`LTM_EN_W{1'b0}};
					en_block_q <= 1'b0;
					fault_q    <= 1'b0;
					wstat_q    <= 1'b0;
					rx_q       <= 1'b1;
					drv_q      <= 1'b0;
				end else begin
					mode_q     <= mode_d;
					bus_prev_q <= bus_dom;
					// mode stays wake; rearm
					// Wake wins over a same-cycle rearm
					if (wake_now && (mode_d == mode_q)) begin
						woken_q <= 1'b1;
					end else if (rearm_all || (mode_d != mode_q)) begin
						woken_q <= 1'b0;
					end
					// count starts only on a falling bus edge
					if (!armed || !bus_dom) begin
						wk_cnt_q <= {`LTM_WK_W{1'b0}};
					end else if ((wk_cnt_q == {`LTM_WK_W{1'b0}}) &&
						bus_prev_q) begin
						// Already dominant when armed: no edge yet
						wk_cnt_q <= {`LTM_WK_W{1'b0}};
					end else if (wk_cnt_q != `LTM_WAKE_CYC) begin
						wk_cnt_q <= wk_cnt_q + 1'b1;
					end
					if (!armed) begin
						wk_long_q <= 1'b0;
					end else if (bus_dom) begin
						wk_long_q <= (wk_cnt_q == `LTM_WAKE_CYC);
					end else if (!bus_prev_q) begin
						wk_long_q <= 1'b0;
					end
					// Bus dominant duration
					if (!bus_dom) begin
						bus_cnt_q <= {`LTM_TO_W{1'b0}};
					end else if (bus_cnt_q != DOM_TO_CYC) begin
						bus_cnt_q <= bus_cnt_q + 1'b1;
					end
					if (!tx_dom || !drive_ok || !cfg_q[`LTM_CFG_TXTO_EN]) begin
						txto_cnt_q <= {`LTM_TO_W{1'b0}};
					end else if (txto_cnt_q != DOM_TO_CYC) begin
						txto_cnt_q <= txto_cnt_q + 1'b1;
					end
					if (!tx_dom) begin
						tx_to_q <= 1'b0;
					end else if (txto_hit) begin
						tx_to_q <= 1'b1;
					end
					if ((mode_d == `LTM_MODE_NORMAL) &&
						(mode_q != `LTM_MODE_NORMAL)) begin
						en_cnt_q   <= `LTM_EN_CYC;
						en_block_q <= 1'b1;
					end else if (en_cnt_q != {`LTM_EN_W{1'b0}}) begin
						en_cnt_q <= en_cnt_q - 1'b1;
					end else if (!tx_dom) begin
						en_block_q <= 1'b0;
					end
					// Fault flag, set wins over clear
					if (fault_set) begin
						fault_q <= 1'b1;
					end else if (wr_fault && pwdata[i]) begin
						fault_q <= 1'b0;
					end
					// wake source, set wins over clear
					if (wake_now) begin
						wstat_q <= 1'b1;
					end else if (wr_wake && pwdata[i]) begin
						wstat_q <= 1'b0;
					end
					// receive low after wake, held until rearm or mode change
					if (woken_q || wake_now) begin
						rx_q <= 1'b0;
					end else if ((mode_q == `LTM_MODE_NORMAL) ||
						(mode_q == `LTM_MODE_RXONLY)) begin
						rx_q <= bus_f[i];
					end else begin
						rx_q <= 1'b1;
					end
					// driver follows transmit only when allowed
					drv_q <= drive_ok && tx_dom && !txto_hit;
				end
			end

			assign mode_all[2*i+1:2*i] = mode_q;
			assign fault_all[i]        = fault_q;
			assign wstat_all[i]        = wstat_q;
			assign woken_all[i]        = woken_q;
			assign txto_all[i]         = tx_to_q;
			assign wk_ev[i]            = wake_now;
			assign rx_serial_out[i]    = rx_q;
			assign bus_drive_dom[i]    = drv_q;
		end
	endgenerate

endmodule

// ---- tb/ltm_lin_mode_ctrl_asserts.sv ----
`timescale 1ns/1ps
`include "ltm_consts.vh"
module ltm_lin_mode_ctrl_chk #(
	parameter [`LTM_TO_W-1:0] DOM_TO_CYC = `LTM_DOM_TO_CYC
) (
	input wire       pclk,
	input wire       presetn,
	input wire [2:0] chip_mode,
	input wire [3:0] tx_serial_in,
	input wire       supply_uv_in,
	input wire [3:0] rx_serial_out,
	input wire [3:0] bus_drive_dom,
	input wire       wake_irq_pulse,
	input wire       watchdog_enable_req,
	input wire       restart_req
);
	// One clock domain, quiet during reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rst_idle;
		$rose(presetn) |-> rx_serial_out == 4'hF && bus_drive_dom == 4'h0;
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("outputs not idle after reset");
	property p_tx_idle;
		(tx_serial_in[0])[*8] |-> !bus_drive_dom[0];
	endproperty
	a_tx_idle: assert property (p_tx_idle)
		else $error("bus driven while transmit recessive");
	property p_uv;
		(supply_uv_in)[*8] |-> bus_drive_dom == 4'h0;
	endproperty
	a_uv: assert property (p_uv)
		else $error("bus driven under supply fault");
	property p_nrm_only;
		(chip_mode != `LTM_CM_NORMAL)[*8] |-> bus_drive_dom == 4'h0;
	endproperty
	a_nrm_only: assert property (p_nrm_only)
		else $error("bus driven outside chip normal mode");
	property p_irq_mode;
		wake_irq_pulse |-> chip_mode inside {`LTM_CM_NORMAL, `LTM_CM_STOP};
	endproperty
	a_irq_mode: assert property (p_irq_mode)
		else $error("wake interrupt in wrong chip mode");
	property p_irq_rx;
		wake_irq_pulse |=> !wake_irq_pulse ##[0:2] rx_serial_out != 4'hF;
	endproperty
	a_irq_rx: assert property (p_irq_rx)
		else $error("wake interrupt without low receive");
	property p_wd_stop;
		watchdog_enable_req |-> chip_mode == `LTM_CM_STOP;
	endproperty
	a_wd_stop: assert property (p_wd_stop)
		else $error("watchdog request outside stop mode");
	property p_rs_sleep;
		restart_req |-> !wake_irq_pulse &&
			chip_mode inside {`LTM_CM_SLEEP, `LTM_CM_FAILSAFE};
	endproperty
	a_rs_sleep: assert property (p_rs_sleep)
		else $error("restart request in wrong chip mode");
	// Main wake paths reached
	c_irq: cover property (wake_irq_pulse);
	c_wd: cover property (watchdog_enable_req);
	c_rs: cover property (restart_req);
endmodule
bind ltm_lin_mode_ctrl ltm_lin_mode_ctrl_chk #(.DOM_TO_CYC(DOM_TO_CYC)) i_chk (
	.pclk(pclk), .presetn(presetn), .chip_mode(chip_mode),
	.tx_serial_in(tx_serial_in), .supply_uv_in(supply_uv_in),
	.rx_serial_out(rx_serial_out), .bus_drive_dom(bus_drive_dom),
	.wake_irq_pulse(wake_irq_pulse), .restart_req(restart_req),
	.watchdog_enable_req(watchdog_enable_req)
);

// ---- tb/ltm_host_model.sv ----
`timescale 1ns/1ps
module ltm_host_model (
	input  wire        pclk,
	input  wire  [3:0] tx_cmd,
	input  wire  [3:0] bus_pull,
	input  wire  [3:0] bus_drive_dom,
	output logic [3:0] tx_serial_in = 4'hF, // Recessive until commanded
	output wire  [3:0] bus_level_in
);
	always @(posedge pclk) begin
		tx_serial_in <= tx_cmd;
	end
	// Wired-AND bus with pull-up; any node pulls it dominant
	assign bus_level_in = bus_pull & ~bus_drive_dom;
endmodule

// ---- tb/ltm_lin_mode_ctrl_bench.sv ----
`timescale 1ns/1ps
`include "ltm_consts.vh"
module ltm_lin_mode_ctrl_bench;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, chip_mode_load, supply_uv_in;
	logic [2:0]  chip_mode;
	logic [3:0]  tx_cmd, bus_pull, tx_serial_in, bus_level_in;
	logic [3:0]  rx_serial_out, bus_drive_dom;
	logic        low_slope_out, wake_irq_pulse, watchdog_enable_req;
	logic        restart_req;
	int          num_errors = 0, checks = 0, n_irq = 0, n_wd = 0, n_rs = 0;
	ltm_lin_mode_ctrl #(.DOM_TO_CYC(22'hC8)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chip_mode(chip_mode),
		.chip_mode_load(chip_mode_load), .tx_serial_in(tx_serial_in),
		.bus_level_in(bus_level_in), .supply_uv_in(supply_uv_in),
		.rx_serial_out(rx_serial_out), .bus_drive_dom(bus_drive_dom),
		.low_slope_out(low_slope_out), .wake_irq_pulse(wake_irq_pulse),
		.watchdog_enable_req(watchdog_enable_req),
		.restart_req(restart_req)
	);
	ltm_host_model i_host (
		.pclk(pclk), .tx_cmd(tx_cmd), .bus_pull(bus_pull),
		.bus_drive_dom(bus_drive_dom), .tx_serial_in(tx_serial_in),
		.bus_level_in(bus_level_in)
	);
	// Clock, 8 ns period
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Count single-cycle wake pulses
	always @(posedge pclk) begin
		if (wake_irq_pulse === 1'b1) n_irq <= n_irq + 1;
		if (watchdog_enable_req === 1'b1) n_wd <= n_wd + 1;
		if (restart_req === 1'b1) n_rs <= n_rs + 1;
	end
	// Hang guard
	initial begin
		repeat (60000) @(posedge pclk);
		num_errors++;
		print_verdict;
	end
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer, waiting on pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	task automatic chip(input logic [2:0] m);
		@(posedge pclk);
		chip_mode <= m;
		chip_mode_load <= 1'b1;
		@(posedge pclk);
		chip_mode_load <= 1'b0;
		cyc(10);
	endtask
	// Another node holds channels dominant for len cycles
	task automatic dom(input logic [3:0] m, input int len);
		@(posedge pclk);
		bus_pull <= ~m;
		cyc(len);
		bus_pull <= 4'hF;
		cyc(12);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, chip_mode_load, supply_uv_in} = 0;
		{paddr, pwdata, chip_mode} = 0;
		tx_cmd = 4'hF;
		bus_pull = 4'hF;
		cyc(12);
		presetn <= 1'b1;
		rd(`LTM_OFF_MODE, 32'h0);
		rd(`LTM_OFF_CONFIG, 32'h1);
		chk(low_slope_out, 1'b0);
		chip(`LTM_CM_NORMAL);
		// Early dominant during enabling, then timeout and recovery
		wr(`LTM_OFF_MODE, 32'h3);
		tx_cmd <= 4'hE;
		cyc(1400);
		chk(bus_drive_dom, 4'h0);
		tx_cmd <= 4'hF;
		cyc(10);
		tx_cmd <= 4'hE;
		cyc(10);
		chk(bus_drive_dom, 4'h1);
		cyc(250);
		chk(bus_drive_dom, 4'h0);
		rd(`LTM_OFF_FAULT, 32'h1);
		tx_cmd <= 4'hF;
		cyc(10);
		tx_cmd <= 4'hE;
		cyc(10);
		chk(bus_drive_dom, 4'h1);
		wr(`LTM_OFF_FAULT, 32'hF);
		wr(`LTM_OFF_CONFIG, 32'h2);
		cyc(300);
		chk(bus_drive_dom, 4'h1);
		chk(low_slope_out, 1'b1);
		rd(`LTM_OFF_FAULT, 32'h1);
		rd(`LTM_OFF_MODE, 32'h3);
		supply_uv_in <= 1'b1;
		cyc(20);
		chk(bus_drive_dom, 4'h0);
		supply_uv_in <= 1'b0;
		cyc(20);
		chk(bus_drive_dom, 4'h1);
		tx_cmd <= 4'hF;
		wr(`LTM_OFF_FAULT, 32'hF);
		rd(`LTM_OFF_FAULT, 32'h0);
		// Stop mode: fallback, refusals, allowed codes
		chip(`LTM_CM_STOP);
		rd(`LTM_OFF_MODE, 32'h2);
		wr(`LTM_OFF_MODE, 32'hF);
		rd(`LTM_OFF_MODE, 32'h2);
		wr(`LTM_OFF_MODE, 32'h9);
		rd(`LTM_OFF_MODE, 32'h9);
		wr(`LTM_OFF_CONFIG, 32'h4);
		rd(`LTM_OFF_CONFIG, 32'h6);
		dom(4'h2, 260);
		rd(`LTM_OFF_FAULT, 32'h2);
		// Wake filter, off channel ignored, wake effects
		dom(4'h5, 2000);
		chk(n_irq, 0);
		dom(4'h5, 4000);
		chk(n_irq, 1);
		chk(n_wd, 1);
		chk(rx_serial_out, 4'hE);
		rd(`LTM_OFF_WAKE, 32'h1);
		rd(`LTM_OFF_MODE, 32'h9);
		rd(`LTM_OFF_STATUS, 32'h201);
		wr(`LTM_OFF_MODE, 32'hA);
		cyc(2);
		chk(rx_serial_out, 4'hF);
		wr(`LTM_OFF_MODE, 32'h9);
		dom(4'h1, 4000);
		chk(n_irq, 2);
		chip(`LTM_CM_STOP);
		chk(rx_serial_out, 4'hF);
		dom(4'h1, 4000);
		chk(n_irq, 3);
		chip(`LTM_CM_SLEEP);
		dom(4'h1, 4000);
		chk(n_rs, 1);
		chk(n_irq, 3);
		chk(rx_serial_out, 4'hE);
		chip(`LTM_CM_FAILSAFE);
		rd(`LTM_OFF_MODE, 32'h55);
		wr(`LTM_OFF_MODE, 32'h0);
		rd(`LTM_OFF_MODE, 32'h0);
		chip(`LTM_CM_NORMAL);
		rd(8'h40, 32'h0);
		chk(pslverr, 1'b1);
		print_verdict;
	end
endmodule
